// file: vfc_pkg.sv
// Purpose: shared constants and carriers for the video filter / view / field command block
// Assumes: commands arrive pre-parsed as opcode, argument kind, and numeric value
// Notes:   bandwidth in hertz, distance in millimeters, both unsigned integers
package vfc_pkg;

    localparam int BW_W           = 32;
    localparam int DIST_W         = 32;
    localparam int BW_STEPS       = 14;
    localparam int BW_IDX_W       = 4;
    localparam int RESP_W         = 32;

    // numeric argument unit codes
    localparam logic [2:0] UNIT_NONE = 3'h0;
    localparam logic [2:0] UNIT_KILO = 3'h1;
    localparam logic [2:0] UNIT_MEGA = 3'h2;
    localparam logic [2:0] UNIT_FT   = 3'h3;
    localparam logic [2:0] UNIT_M    = 3'h4;
    localparam logic [2:0] UNIT_KM   = 3'h5;
    localparam logic [2:0] UNIT_MI   = 3'h6;

    // view item bit positions
    localparam int VIEW_A     = 0;
    localparam int VIEW_B     = 1;
    localparam int VIEW_C     = 2;
    localparam int VIEW_D     = 3;
    localparam int VIEW_MINUS = 4;
    localparam int VIEW_WFALL = 5;
    localparam int VIEW_ITEMS = 6;

    localparam logic [2:0] ANT_TBL_MIN = 3'h1;
    localparam logic [2:0] ANT_TBL_MAX = 3'h5;

    // reset values
    localparam logic                ANT_TBL_RST  = 1'b0;
    localparam logic [2:0]          ANT_TBL_INIT = 3'h1;
    localparam logic [BW_IDX_W-1:0] BW_IDX_INIT  = 4'h0;
    localparam logic [DIST_W-1:0]   DIST_INIT_MM = 32'h0000_0BB8;
    localparam logic [VIEW_ITEMS-1:0] VIEW_INIT  = 6'h01;

    // unit conversion factors, millimeters per unit and hertz per unit
    localparam logic [DIST_W-1:0] MM_PER_M   = 32'h0000_03E8;
    localparam logic [DIST_W-1:0] MM_PER_KM  = 32'h000F_4240;
    localparam logic [DIST_W-1:0] MM_PER_FT  = 32'h0000_0131;
    localparam logic [DIST_W-1:0] MM_PER_MI  = 32'h0018_8E6E;
    localparam logic [BW_W-1:0]   HZ_PER_K   = 32'h0000_03E8;
    localparam logic [BW_W-1:0]   HZ_PER_M   = 32'h000F_4240;

    typedef enum logic [3:0] {
        OP_VF_MODE,
        OP_VF_MODE_Q,
        OP_VF_BW,
        OP_VF_BW_Q,
        OP_VF_EN,
        OP_VF_EN_Q,
        OP_VIEW,
        OP_VIEW_Q,
        OP_ANT_TBL,
        OP_ANT_TBL_Q,
        OP_FS_DEST,
        OP_FS_DEST_Q,
        OP_DIST,
        OP_DIST_Q
    } vfc_op_type;

    typedef enum logic [1:0] {
        ARG_NONE,
        ARG_KEY_ON,
        ARG_KEY_OFF,
        ARG_NUMBER
    } vfc_arg_type;

    typedef enum logic [1:0] {
        DEST_A,
        DEST_B,
        DEST_C
    } vfc_dest_type;

    typedef struct packed {
        vfc_op_type            op;
        vfc_arg_type           kind;
        logic [2:0]            unit;
        logic [VIEW_ITEMS-1:0] item_sel;
        logic [VIEW_ITEMS-1:0] item_val;
        logic                  item_all;
        logic [BW_W-1:0]       value;
    } vfc_cmd_type;

    typedef struct packed {
        vfc_op_type            op;
        logic                  auto_mode;
        logic                  enabled;
        logic [VIEW_ITEMS-1:0] view_mask;
        logic [VIEW_ITEMS-1:0] view_state;
        logic [RESP_W-1:0]     value;
    } vfc_resp_type;

endpackage

// file: vfc_cmds.sv
// Purpose: settings store and reply former for video filter, view and field strength commands
// Assumes: one pre-parsed command per valid cycle, replies taken on RESP_VALID
// Notes:   bandwidths form a 1-3 ladder from 1 Hz upward; distance held in millimeters
`timescale 1ns/1ps

module vfc_cmds
    import vfc_pkg::*;
#(
    parameter int N_STEPS = BW_STEPS
) (
    input  wire logic                  REF_CLK,
    input  wire logic                  SYS_RST,
    input  wire logic                  CMD_VALID,
    input  wire vfc_cmd_type           CMD,
    input  wire logic [BW_IDX_W-1:0]   AUTO_BW_IDX,
    input  wire logic                  LOCAL_BW_SET,
    input  wire logic [BW_IDX_W-1:0]   LOCAL_BW_IDX,
    output logic                       RESP_VALID,
    output vfc_resp_type               RESP,
    output logic                       CMD_ERROR,
    output logic                       VF_AUTO,
    output logic                       VF_ENABLE,
    output logic [BW_IDX_W-1:0]        VF_BW_IDX,
    output logic [VIEW_ITEMS-1:0]      VIEW_ON,
    output logic [2:0]                 ANT_TABLE,
    output vfc_dest_type               FS_DEST,
    output logic [DIST_W-1:0]          ANT_DIST_MM
);

    // refuse ladders the index cannot address
    if (N_STEPS < 2 || N_STEPS > (1 << BW_IDX_W)) begin : g_bad_steps
        $error("N_STEPS out of range");
    end

    // width in hertz of ladder step
    function automatic logic [BW_W-1:0] step_hz(input logic [BW_IDX_W-1:0] idx);
        logic [BW_W-1:0] v;
        v = 32'h0000_0001;
        for (int i = 0; i < (1 << BW_IDX_W); i++) begin
            if (i < 32'(idx) && i % 2 == 0) begin
                v = BW_W'(v * 3);
            end else if (i < 32'(idx)) begin
                v = BW_W'((v * 10) / 3);
            end
        end
        return v;
    endfunction

    function automatic logic [BW_W-1:0] abs_diff(input logic [BW_W-1:0] a,
                                                 input logic [BW_W-1:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [BW_W-1:0] scale(input logic [BW_W-1:0] v,
                                              input logic [BW_W-1:0] k);
        logic [2*BW_W-1:0] p;
        p = v * k;
        return (p[2*BW_W-1:BW_W] != '0) ? '1 : p[BW_W-1:0];
    endfunction

    logic                  auto_reg, auto_next;
    logic                  en_reg, en_next;
    logic [BW_IDX_W-1:0]   bw_reg, bw_next;
    logic [VIEW_ITEMS-1:0] view_reg, view_next;
    logic [2:0]            ant_reg, ant_next;
    vfc_dest_type          dest_reg, dest_next;
    logic [DIST_W-1:0]     dist_reg, dist_next;
    logic                  rv_reg, rv_next;
    vfc_resp_type          resp_reg, resp_next;
    logic                  err_reg, err_next;
    logic [BW_IDX_W-1:0]   vfbw_reg, vfbw_next;
    logic [BW_W-1:0]       req_hz;
    logic [BW_IDX_W-1:0]   near_idx;
    logic [DIST_W-1:0]     req_mm;
    logic                  unit_ok;

    // numeric bandwidth in hertz
    always_comb begin
        unit_ok = 1'b1;
        unique case (CMD.unit)
            UNIT_NONE: req_hz = CMD.value;
            UNIT_KILO: req_hz = scale(CMD.value, HZ_PER_K);
            UNIT_MEGA: req_hz = scale(CMD.value, HZ_PER_M);
            default: begin
                req_hz  = CMD.value;
                unit_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        near_idx = '0;
        for (int i = 1; i < N_STEPS; i++) begin
            if (abs_diff(step_hz(BW_IDX_W'(i)), req_hz) < abs_diff(step_hz(near_idx), req_hz)) begin
                near_idx = BW_IDX_W'(i);
            end
        end
    end

    always_comb begin
        unique case (CMD.unit)
            UNIT_FT: req_mm = scale(CMD.value, MM_PER_FT);
            UNIT_KM: req_mm = scale(CMD.value, MM_PER_KM);
            UNIT_MI: req_mm = scale(CMD.value, MM_PER_MI);
            default: req_mm = scale(CMD.value, MM_PER_M);
        endcase
    end

    always_comb begin
        auto_next = auto_reg;
        en_next   = en_reg;
        bw_next   = bw_reg;
        view_next = view_reg;
        ant_next  = ant_reg;
        dest_next = dest_reg;
        dist_next = dist_reg;
        rv_next   = 1'b0;
        err_next  = 1'b0;
        resp_next = resp_reg;
        // local panel selection in fixed mode
        if (LOCAL_BW_SET && !auto_reg && 32'(LOCAL_BW_IDX) < N_STEPS) begin
            bw_next = LOCAL_BW_IDX;
        end
        if (CMD_VALID) begin
            resp_next.op         = CMD.op;
            resp_next.auto_mode  = auto_reg;
            resp_next.enabled    = en_reg;
            resp_next.view_mask  = '0;
            resp_next.view_state = view_reg;
            resp_next.value      = '0;
            unique case (CMD.op)
                OP_VF_MODE: begin
                    if (CMD.kind == ARG_KEY_ON) begin
                        auto_next = 1'b1;
                    end else if (CMD.kind == ARG_KEY_OFF) begin
                        auto_next = 1'b0;
                        if (auto_reg) begin
                            bw_next = AUTO_BW_IDX;
                        end
                    end else begin
                        err_next = 1'b1;
                    end
                end
                OP_VF_BW: begin
                    if (CMD.kind == ARG_KEY_ON || CMD.kind == ARG_KEY_OFF) begin
                        en_next = (CMD.kind == ARG_KEY_ON);
                    end else if (CMD.kind == ARG_NUMBER && unit_ok) begin
                        bw_next = near_idx;
                        en_next = 1'b1;
                    end else begin
                        err_next = 1'b1;
                    end
                end
                OP_VF_EN: begin
                    if (CMD.kind == ARG_KEY_ON || CMD.kind == ARG_KEY_OFF) begin
                        en_next = (CMD.kind == ARG_KEY_ON);
                    end else begin
                        err_next = 1'b1;
                    end
                end
                OP_VIEW: begin
                    for (int i = 0; i < VIEW_ITEMS; i++) begin
                        if (CMD.item_sel[i]) begin
                            view_next[i] = CMD.item_val[i];
                        end
                    end
                    err_next = (CMD.item_sel == '0);
                end
                OP_ANT_TBL: begin
                    if (CMD.kind == ARG_NUMBER && CMD.unit == UNIT_NONE
                        && CMD.value >= BW_W'(ANT_TBL_MIN) && CMD.value <= BW_W'(ANT_TBL_MAX)) begin
                        ant_next = CMD.value[2:0];
                    end else begin
                        err_next = 1'b1;
                    end
                end
                OP_FS_DEST: begin
                    if (CMD.kind == ARG_NUMBER && CMD.value <= BW_W'(DEST_C)) begin
                        dest_next = vfc_dest_type'(CMD.value[1:0]);
                    end else begin
                        err_next = 1'b1;
                    end
                end
                OP_DIST: begin
                    if (CMD.kind == ARG_NUMBER && CMD.unit >= UNIT_FT
                        && CMD.unit <= UNIT_MI) begin
                        dist_next = req_mm;
                    end else if (CMD.kind == ARG_NUMBER && CMD.unit == UNIT_NONE) begin
                        dist_next = req_mm;
                    end else begin
                        err_next = 1'b1;
                    end
                end
                OP_VF_MODE_Q: rv_next = 1'b1;
                OP_VF_BW_Q: begin
                    rv_next         = 1'b1;
                    resp_next.value = step_hz(bw_reg);
                end
                OP_VF_EN_Q: rv_next = 1'b1;
                OP_VIEW_Q: begin
                    rv_next             = 1'b1;
                    resp_next.view_mask = CMD.item_all ? '1 : CMD.item_sel;
                end
                OP_ANT_TBL_Q: begin
                    rv_next         = 1'b1;
                    resp_next.value = RESP_W'(ant_reg);
                end
                OP_FS_DEST_Q: begin
                    rv_next         = 1'b1;
                    resp_next.value = RESP_W'(dest_reg);
                end
                OP_DIST_Q: begin
                    rv_next         = 1'b1;
                    resp_next.value = dist_reg;
                end
                default: err_next = 1'b1;
            endcase
        end
        // active width, fixed or automatic
        vfbw_next = auto_next ? AUTO_BW_IDX : bw_next;
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            auto_reg <= 1'b1;
            en_reg   <= 1'b0;
            bw_reg   <= BW_IDX_INIT;
            view_reg <= VIEW_INIT;
            ant_reg  <= ANT_TBL_INIT;
            dest_reg <= DEST_A;
            dist_reg <= DIST_INIT_MM;
            rv_reg   <= 1'b0;
            err_reg  <= 1'b0;
            resp_reg <= '0;
            vfbw_reg <= BW_IDX_INIT;
        end else begin
            auto_reg <= auto_next;
            en_reg   <= en_next;
            bw_reg   <= bw_next;
            view_reg <= view_next;
            ant_reg  <= ant_next;
            dest_reg <= dest_next;
            dist_reg <= dist_next;
            rv_reg   <= rv_next;
            err_reg  <= err_next;
            resp_reg <= resp_next;
            vfbw_reg <= vfbw_next;
        end
    end

    assign RESP_VALID  = rv_reg;
    assign RESP        = resp_reg;
    assign CMD_ERROR   = err_reg;
    assign VF_AUTO     = auto_reg;
    assign VF_ENABLE   = en_reg;
    assign VF_BW_IDX   = vfbw_reg;
    assign VIEW_ON     = view_reg;
    assign ANT_TABLE   = ant_reg;
    assign FS_DEST     = dest_reg;
    assign ANT_DIST_MM = dist_reg;

endmodule

// file: vfc_cmds_properties.sv
// Purpose: port checker for the command block
// Assumes: one clock domain, reset synchronous active high
// Notes:   bound to every vfc_cmds instance
`timescale 1ns/1ps
module vfc_cmds_chk
    import vfc_pkg::*;
(
    input wire logic                REF_CLK,
    input wire logic                SYS_RST,
    input wire logic                CMD_VALID,
    input wire vfc_cmd_type         CMD,
    input wire logic [BW_IDX_W-1:0] AUTO_BW_IDX,
    input wire logic                LOCAL_BW_SET,
    input wire logic                RESP_VALID,
    input wire logic                CMD_ERROR,
    input wire logic                VF_AUTO,
    input wire logic                VF_ENABLE,
    input wire logic [BW_IDX_W-1:0] VF_BW_IDX,
    input wire logic [2:0]          ANT_TABLE,
    input wire vfc_dest_type        FS_DEST,
    input wire logic [DIST_W-1:0]   ANT_DIST_MM
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    wire logic num = CMD_VALID && CMD.kind == ARG_NUMBER && CMD.unit == UNIT_NONE;
    wire logic tbl = CMD_VALID && CMD.op == OP_ANT_TBL;
    AST_QUERY_REPLY: assert property (CMD_VALID && CMD.op[0] |=> RESP_VALID && !CMD_ERROR)
        else $error("query gave no reply");
    AST_VIEW_SILENT: assert property (CMD_VALID && CMD.op == OP_VIEW |=> !RESP_VALID)
        else $error("view set gave a reply");
    AST_MODE_AUTO: assert property (
        CMD_VALID && CMD.op == OP_VF_MODE && CMD.kind == ARG_KEY_ON |=> VF_AUTO)
        else $error("auto mode not entered");
    AST_FIXED_COPY: assert property (CMD_VALID && VF_AUTO && CMD.op == OP_VF_MODE &&
        CMD.kind == ARG_KEY_OFF |=> !VF_AUTO && VF_BW_IDX == $past(AUTO_BW_IDX))
        else $error("fixed entry lost auto width");
    AST_BW_NUM_EN: assert property (num && CMD.op == OP_VF_BW |=> VF_ENABLE)
        else $error("numeric width left filter off");
    AST_BW_OFF: assert property (
        CMD_VALID && CMD.op == OP_VF_BW && CMD.kind == ARG_KEY_OFF |=> !VF_ENABLE)
        else $error("off argument ignored");
    AST_EN_KEEP_BW: assert property (
        CMD_VALID && CMD.op == OP_VF_EN && !VF_AUTO && !LOCAL_BW_SET |=> $stable(VF_BW_IDX))
        else $error("enable changed width");
    AST_TBL_SET: assert property (
        num && tbl && CMD.value inside {[1:5]} |=> {29'h0, ANT_TABLE} == $past(CMD.value))
        else $error("table not taken");
    AST_TBL_BAD: assert property (
        tbl && (CMD.value == 0 || CMD.value > 5) |=> CMD_ERROR && $stable(ANT_TABLE))
        else $error("bad table accepted");
    AST_DEST_SET: assert property (
        num && CMD.op == OP_FS_DEST && CMD.value < 3 |=> {30'h0, FS_DEST} == $past(CMD.value))
        else $error("destination not taken");
    AST_DIST_M: assert property (CMD_VALID && CMD.op == OP_DIST &&
        CMD.unit == UNIT_M && CMD.value < 1000 |=> ANT_DIST_MM == $past(CMD.value) * MM_PER_M)
        else $error("distance not converted");
    cover property (num && CMD.op == OP_VF_BW);
    cover property (tbl ##1 CMD_ERROR);
    cover property (CMD_VALID && CMD.op == OP_VIEW_Q ##1 RESP_VALID);
endmodule
bind vfc_cmds vfc_cmds_chk chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID),
    .CMD(CMD), .AUTO_BW_IDX(AUTO_BW_IDX), .LOCAL_BW_SET(LOCAL_BW_SET), .RESP_VALID(RESP_VALID),
    .CMD_ERROR(CMD_ERROR), .VF_AUTO(VF_AUTO), .VF_ENABLE(VF_ENABLE), .VF_BW_IDX(VF_BW_IDX),
    .ANT_TABLE(ANT_TABLE), .FS_DEST(FS_DEST), .ANT_DIST_MM(ANT_DIST_MM));

// file: vfc_ctl_model.sv
// Purpose: remote controller model issuing parsed commands
// Assumes: bench raises go for each cycle with a command to send
// Notes:   command bus scrambled while idle
`timescale 1ns/1ps
module vfc_ctl_model
    import vfc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        go,
    input  wire vfc_cmd_type req,
    output logic             cmd_valid,
    output vfc_cmd_type      cmd
);
    logic        valid_reg, valid_next;
    vfc_cmd_type cmd_reg, cmd_next;
    always_comb begin
        valid_next = go;
        cmd_next   = go ? req : vfc_cmd_type'(~cmd_reg);
        if (go && req.op == OP_ANT_TBL) cmd_next.unit = UNIT_NONE;
    end
    always_ff @(posedge clk) begin
        valid_reg <= valid_next;
        cmd_reg   <= cmd_next;
    end
    assign cmd_valid = valid_reg;
    assign cmd       = cmd_reg;
endmodule

// file: video_filter_view_field_cmds_tb.sv
// Purpose: self-checking bench for the command block
// Assumes: partner presents each command one cycle after go
// Notes:   replies noted in a queue, checked by a monitor
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module video_filter_view_field_cmds_tb;
    import vfc_pkg::*;
    typedef struct {logic err; logic [1:0] sel; logic [31:0] msk, val;} vfc_exp_type;
    logic         clk = 1'h0, rst = 1'h1, go = 1'h0, lset = 1'h0;
    logic [3:0]   aidx = 4'h0, lidx = 4'h0, bidx;
    vfc_cmd_type  req = '0, cmd;
    logic         cval, rv, ce, vauto, ven;
    vfc_resp_type resp;
    logic [5:0]   von, mview = 6'h01, s;
    logic [2:0]   atbl, mtbl = 3'h1;
    vfc_dest_type fsd;
    logic [31:0]  dmm, mdist;
    logic [1:0]   mdest;
    vfc_exp_type  q[$];
    int           errors = 0, tests_run = 0;
    logic [7:0]   bwv [5] = '{8'h19, 8'h02, 8'h03, 8'h01, 8'h07};
    logic [2:0]   bwu [5] = '{UNIT_NONE, UNIT_NONE, UNIT_KILO, UNIT_MEGA, UNIT_NONE};
    logic [3:0]   bwi [5] = '{4'h3, 4'h0, 4'h7, 4'hC, 4'h2};
    logic [7:0]   dv [6] = '{8'h07, 8'h0A, 8'h02, 8'h01, 8'h05, 8'h09};
    logic [2:0]   du [6] = '{UNIT_M, UNIT_FT, UNIT_KM, UNIT_MI, UNIT_NONE, UNIT_KILO};
    logic [31:0]  df [6] = '{MM_PER_M, MM_PER_FT, MM_PER_KM, MM_PER_MI, MM_PER_M, 32'h0};
    vfc_ctl_model ctl (.clk(clk), .go(go), .req(req), .cmd_valid(cval), .cmd(cmd));
    vfc_cmds #(.N_STEPS(BW_STEPS)) dut (.REF_CLK(clk), .SYS_RST(rst), .CMD_VALID(cval),
        .CMD(cmd), .AUTO_BW_IDX(aidx), .LOCAL_BW_SET(lset), .LOCAL_BW_IDX(lidx),
        .RESP_VALID(rv), .RESP(resp), .CMD_ERROR(ce), .VF_AUTO(vauto), .VF_ENABLE(ven),
        .VF_BW_IDX(bidx), .VIEW_ON(von), .ANT_TABLE(atbl), .FS_DEST(fsd), .ANT_DIST_MM(dmm));
    always #2.5 clk = ~clk;
    function automatic logic [31:0] hz(input logic [3:0] i);
        logic [31:0] p;
        p = 32'h0000_0001;
        repeat (i / 2) p = p * 32'h0000_000A;
        return i[0] ? p * 32'h0000_0003 : p;
    endfunction
    task automatic send(vfc_op_type op, vfc_arg_type k, logic [2:0] u, logic [5:0] sl,
                        logic [5:0] vl, logic [31:0] x);
        @(posedge clk);
        go  <= 1'h1;
        req <= '{op, k, u, sl, vl, sl == 6'h00, x};
    endtask
    task automatic exp(logic e, logic [1:0] k, logic [31:0] m, logic [31:0] x);
        q.push_back('{e, k, m, x});
    endtask
    task automatic ask(vfc_op_type op, logic [5:0] sl, logic [1:0] k, logic [31:0] x);
        send(op, ARG_NONE, UNIT_NONE, sl, 6'h00, 32'h0);
        exp(1'h0, k, k == 2'h2 ? {26'h0, sl == 6'h00 ? 6'h3F : sl}
            : (k == 2'h1 ? 32'h0000_0001 : 32'hFFFF_FFFF), x);
    endtask
    task automatic idle(int n);
        @(posedge clk);
        go <= 1'h0;
        repeat (n - 1) @(posedge clk);
    endtask
    task automatic give_verdict();
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin : mon
        vfc_exp_type e;
        logic [31:0] g;
        if (rv === 1'h1 || ce === 1'h1) begin
            `CHK(q.size() > 0, 1'h1)
            if (q.size() > 0) begin
                e = q.pop_front();
                g = e.sel == 2'h1 ? {31'h0, resp.auto_mode} : resp.value;
                g = e.sel == 2'h2 ? {26'h0, resp.view_state} : g;
                g = e.sel == 2'h3 ? {31'h0, resp.enabled} : g;
                `CHK(ce, e.err)
                if (!e.err && e.sel == 2'h2) `CHK(resp.view_mask, e.msk[5:0])
                if (!e.err) `CHK(g & e.msk, e.val & e.msk)
            end
        end
    end
    initial begin : main
        logic [3:0] r;
        void'($urandom(32'ha34d_e425));
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        `CHK({vauto, von, atbl}, {1'h1, 6'h01, 3'h1})
        for (int k = 0; k < 2; k++) begin
            r = 4'($urandom_range(13));
            aidx <= r;
            send(OP_VF_MODE, ARG_KEY_ON, UNIT_NONE, 6'h00, 6'h00, 32'h0);
            ask(OP_VF_MODE_Q, 6'h00, 2'h1, 32'h1);
            send(OP_VF_MODE, ARG_KEY_OFF, UNIT_NONE, 6'h00, 6'h00, 32'h0);
            ask(OP_VF_MODE_Q, 6'h00, 2'h1, 32'h0);
            ask(OP_VF_BW_Q, 6'h00, 2'h0, hz(r));
        end
        idle(3);
        lset <= 1'h1;
        lidx <= 4'h5;
        idle(1);
        lset <= 1'h0;
        ask(OP_VF_BW_Q, 6'h00, 2'h0, hz(4'h5));
        `CHK(bidx, 4'h5)
        foreach (bwv[i]) begin
            send(OP_VF_BW, ARG_NUMBER, bwu[i], 6'h00, 6'h00, {24'h0, bwv[i]});
            ask(OP_VF_BW_Q, 6'h00, 2'h0, hz(bwi[i]));
        end
        send(OP_VF_BW, ARG_KEY_OFF, UNIT_NONE, 6'h00, 6'h00, 32'h0);
        ask(OP_VF_BW_Q, 6'h00, 2'h0, hz(4'h2));
        ask(OP_VF_EN_Q, 6'h00, 2'h3, 32'h0);
        send(OP_VF_EN, ARG_KEY_OFF, UNIT_NONE, 6'h00, 6'h00, 32'h0);
        ask(OP_VF_BW_Q, 6'h00, 2'h0, hz(4'h2));
        send(OP_VF_BW, ARG_KEY_ON, UNIT_NONE, 6'h00, 6'h00, 32'h0);
        ask(OP_VF_EN_Q, 6'h00, 2'h3, 32'h1);
        idle(3);
        `CHK(ven, 1'h1)
        for (int k = 0; k < 4; k++) begin
            s = 6'($urandom_range(63, 1));
            r = 4'($urandom);
            send(OP_VIEW, ARG_NONE, UNIT_NONE, s, {r, r[1:0]}, 32'h0);
            mview = (mview & ~s) | ({r, r[1:0]} & s);
            ask(OP_VIEW_Q, 6'h00, 2'h2, {26'h0, mview});
            for (int j = 0; j < 6; j++) ask(OP_VIEW_Q, 6'h01 << j, 2'h2, {26'h0, mview});
        end
        idle(3);
        `CHK(von, mview)
        for (int t = 0; t < 8; t++) begin
            send(OP_ANT_TBL, ARG_NUMBER, UNIT_NONE, 6'h00, 6'h00, 32'(t));
            if (t >= 1 && t <= 5) mtbl = 3'(t);
            else exp(1'h1, 2'h0, 32'h0, 32'h0);
            ask(OP_ANT_TBL_Q, 6'h00, 2'h0, {29'h0, mtbl});
        end
        for (int d = 0; d < 4; d++) begin
            send(OP_FS_DEST, ARG_NUMBER, UNIT_NONE, 6'h00, 6'h00, 32'(d));
            if (d < 3) mdest = 2'(d);
            else exp(1'h1, 2'h0, 32'h0, 32'h0);
            ask(OP_FS_DEST_Q, 6'h00, 2'h0, {30'h0, mdest});
        end
        foreach (dv[i]) begin
            send(OP_DIST, ARG_NUMBER, du[i], 6'h00, 6'h00, {24'h0, dv[i]});
            if (du[i] == UNIT_KILO) exp(1'h1, 2'h0, 32'h0, 32'h0);
            else mdist = {24'h0, dv[i]} * df[i];
            ask(OP_DIST_Q, 6'h00, 2'h0, mdist);
        end
        idle(6);
        `CHK({atbl, fsd, dmm}, {mtbl, mdest, mdist})
        `CHK(q.size(), 0)
        give_verdict();
    end
    initial begin : watchdog
        #50us;
        errors++;
        give_verdict();
    end
endmodule
